// ### tmcs_pkg.sv
package tmcs_pkg;
  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [27:0] TMCS_ADDR_DEFER = 28'h8C0623C;
  localparam logic [27:0] TMCS_ADDR_COLL = 28'h8C06240;
  localparam logic [27:0] TMCS_ADDR_SECOND = 28'h8C06244;
  localparam logic [27:0] TMCS_ADDR_ABANDON = 28'h8C06248;
  localparam logic [27:0] TMCS_ADDR_LATE = 28'h8C0624C;
  localparam logic [27:0] TMCS_ADDR_SEED = 28'h8C06250;
  localparam logic [27:0] TMCS_ADDR_STATE = 28'h8C06254;
  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [7:0] TMCS_MAX_TRIES_RST = 8'h10;
  localparam logic [7:0] TMCS_MIN_SEND_RST = 8'h40;
  localparam logic [9:0] TMCS_SEED_RST = 10'h000;
  localparam int TMCS_DEFER_DIV = 256;
  localparam logic [7:0] TMCS_DIV_LAST = 8'(TMCS_DEFER_DIV - 1);
  localparam int TMCS_LM_LSB = 0;
  localparam int TMCS_ENC_LSB = 4;
endpackage

// ### tmcs_stats.sv
`timescale 1ns/10ps
// Notes on behaviour
// - 16-bit loadable defer timer counts only while deferring during a send attempt.
// - defer timer advances once per media byte clock divided by 256.
// - 16-bit loadable counter increments for each attempt that collides.
// - 16-bit loadable counter counts frames failing first try, succeeding second.
// - 8-bit loadable counter counts frames abandoned after max tries exceeded.
// - 8-bit loadable counter counts frames hit by a late collision.
// - collision after minimum send length is late; frame is then given up.
// - 10-bit writable seed initialises the backoff random number generator.
// - a seed write takes effect at any time; hardware keeps overwriting it afterwards.
// - line manager state is read-only in state register bits 3:0.
// - encapsulation state is read-only in state register bits 7:4.
// - frames are tried at most max_tries times; setting resets to 0x10.
// - minimum send length is an 8-bit byte count resetting to 0x40.
module tmcs_stats
  import tmcs_pkg::*;
(
  // clock and reset; clk is the media byte clock
  input wire logic clk,
  input wire logic rst_n,
  // programmed i/o register port
  input wire logic [27:0] pio_addr,
  input wire logic pio_wr,
  input wire logic pio_rd,
  input wire logic [31:0] pio_wdata,
  output logic [31:0] pio_rdata,
  // transmit mac settings
  input wire logic [7:0] max_tries,
  input wire logic [7:0] min_send_length,
  // transmit mac events and status; attempt_collided and attempt_done_ok are one-cycle pulses
  input wire logic deferring,
  input wire logic attempt_collided,
  input wire logic attempt_done_ok,
  input wire logic [7:0] bytes_sent,
  input wire logic [7:0] attempt_num,
  input wire logic [3:0] line_manager_fsm,
  input wire logic [3:0] encap_fsm,
  // decisions back to the transmit mac
  output logic give_up_late,
  output logic give_up_excess,
  output logic [9:0] backoff_rand
);
  logic [15:0] defer_time_count_r;
  logic [15:0] collision_attempt_count_r;
  logic [15:0] second_try_success_count_r;
  logic [7:0] abandoned_frame_count_r;
  logic [7:0] late_hit_frame_count_r;
  logic [9:0] backoff_seed_r;
  logic [7:0] div_r;
  logic tick;
  logic is_late;
  logic is_excess;
  logic wr_defer;
  logic wr_coll;
  logic wr_second;
  logic wr_abandon;
  logic wr_late;
  logic wr_seed;

  // ****************************************
  // decode
  // ****************************************
  assign wr_defer = pio_wr && (pio_addr == TMCS_ADDR_DEFER);
  assign wr_coll = pio_wr && (pio_addr == TMCS_ADDR_COLL);
  assign wr_second = pio_wr && (pio_addr == TMCS_ADDR_SECOND);
  assign wr_abandon = pio_wr && (pio_addr == TMCS_ADDR_ABANDON);
  assign wr_late = pio_wr && (pio_addr == TMCS_ADDR_LATE);
  assign wr_seed = pio_wr && (pio_addr == TMCS_ADDR_SEED);

  // ****************************************
  // collision classification
  // ****************************************
  // late once min_send_length bytes have gone out; late wins over excess
  assign is_late = attempt_collided && (bytes_sent >= min_send_length);
  // attempt_num counts from 1; the last allowed attempt colliding ends the frame
  assign is_excess = attempt_collided && !is_late && (attempt_num >= max_tries);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      give_up_late <= 1'b0;
      give_up_excess <= 1'b0;
    end
    else
    begin
      give_up_late <= is_late;
      give_up_excess <= is_excess;
    end
  end

  // ****************************************
  // defer time base
  // ****************************************
  // free-running divider, so tick length follows the link rate
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div_r <= 8'h00;
    else
      div_r <= div_r + 8'h01;
  end
  assign tick = (div_r == TMCS_DIV_LAST);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      defer_time_count_r <= 16'h0000;
    else if (wr_defer)
      defer_time_count_r <= pio_wdata[15:0];
    else if (deferring && tick)
      defer_time_count_r <= defer_time_count_r + 16'h0001;
  end

  // ****************************************
  // collision counters
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      collision_attempt_count_r <= 16'h0000;
    else if (wr_coll)
      collision_attempt_count_r <= pio_wdata[15:0];
    else if (attempt_collided)
      collision_attempt_count_r <= collision_attempt_count_r + 16'h0001;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      second_try_success_count_r <= 16'h0000;
    else if (wr_second)
      second_try_success_count_r <= pio_wdata[15:0];
    else if (attempt_done_ok && attempt_num == 8'h02)
      second_try_success_count_r <= second_try_success_count_r + 16'h0001;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      abandoned_frame_count_r <= 8'h00;
    else if (wr_abandon)
      abandoned_frame_count_r <= pio_wdata[7:0];
    else if (is_excess)
      abandoned_frame_count_r <= abandoned_frame_count_r + 8'h01;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      late_hit_frame_count_r <= 8'h00;
    else if (wr_late)
      late_hit_frame_count_r <= pio_wdata[7:0];
    else if (is_late)
      late_hit_frame_count_r <= late_hit_frame_count_r + 8'h01;
  end

  // ****************************************
  // backoff seed
  // ****************************************
  // the seed register is itself the lfsr state (x^10 + x^7 + 1), so a read
  // is unpredictable; a write reseeds it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      backoff_seed_r <= TMCS_SEED_RST;
    else if (wr_seed)
      backoff_seed_r <= pio_wdata[9:0];
    // all ones is the xnor lock-up state; only a write lands there, so step out
    else if (&backoff_seed_r)
      backoff_seed_r <= TMCS_SEED_RST;
    else
      backoff_seed_r <= {backoff_seed_r[8:0],
                         ~(backoff_seed_r[9] ^ backoff_seed_r[6])};
  end
  assign backoff_rand = backoff_seed_r;

  // ****************************************
  // read path
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pio_rdata <= 32'h00000000;
    else if (pio_rd)
    begin
      case (pio_addr)
        TMCS_ADDR_DEFER: pio_rdata <= {16'h0000, defer_time_count_r};
        TMCS_ADDR_COLL: pio_rdata <= {16'h0000, collision_attempt_count_r};
        TMCS_ADDR_SECOND: pio_rdata <= {16'h0000, second_try_success_count_r};
        TMCS_ADDR_ABANDON: pio_rdata <= {24'h000000, abandoned_frame_count_r};
        TMCS_ADDR_LATE: pio_rdata <= {24'h000000, late_hit_frame_count_r};
        TMCS_ADDR_SEED: pio_rdata <= {22'h000000, backoff_seed_r};
        TMCS_ADDR_STATE: pio_rdata <= {24'h000000, encap_fsm, line_manager_fsm};
        default: pio_rdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_wr_defer;
    wr_defer;
  endsequence
  sequence s_late_hit;
    attempt_collided && (bytes_sent >= min_send_length);
  endsequence
  sequence s_excess_hit;
    attempt_collided && (bytes_sent < min_send_length) && (attempt_num >= max_tries);
  endsequence
  sequence s_second_ok;
    attempt_done_ok && (attempt_num == 8'h02);
  endsequence

  a_defer_load: assert property (@(posedge clk) disable iff (!rst_n)
    s_wr_defer |=> defer_time_count_r == $past(pio_wdata[15:0]))
    else $error("defer load lost");
  a_defer_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (!wr_defer && !(deferring && tick)) |=> $stable(defer_time_count_r))
    else $error("defer timer moved without cause");
  a_defer_step: assert property (@(posedge clk) disable iff (!rst_n)
    (!wr_defer && deferring && tick)
      |=> defer_time_count_r == $past(defer_time_count_r) + 16'h0001)
    else $error("defer timer missed a tick");
  a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> !tick [*8])
    else $error("tick too frequent");

  a_coll_count: assert property (@(posedge clk) disable iff (!rst_n)
    (attempt_collided && !wr_coll)
      |=> collision_attempt_count_r == $past(collision_attempt_count_r) + 16'h0001)
    else $error("collision not counted");
  a_coll_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (!attempt_collided && !wr_coll)
      |=> $stable(collision_attempt_count_r))
    else $error("collision counter moved without cause");
  a_coll_load: assert property (@(posedge clk) disable iff (!rst_n)
    wr_coll |=> collision_attempt_count_r == $past(pio_wdata[15:0]))
    else $error("collision counter load lost");
  a_second_try: assert property (@(posedge clk) disable iff (!rst_n)
    (attempt_done_ok && attempt_num != 8'h02 && !wr_second)
      |=> $stable(second_try_success_count_r))
    else $error("second try counter moved");
  a_second_count: assert property (@(posedge clk) disable iff (!rst_n)
    s_second_ok ##0 !wr_second
      |=> second_try_success_count_r == $past(second_try_success_count_r) + 16'h0001)
    else $error("second try success not counted");
  a_second_load: assert property (@(posedge clk) disable iff (!rst_n)
    wr_second |=> second_try_success_count_r == $past(pio_wdata[15:0]))
    else $error("second try counter load lost");
  a_abandon_count: assert property (@(posedge clk) disable iff (!rst_n)
    (is_excess && !wr_abandon)
      |=> abandoned_frame_count_r == $past(abandoned_frame_count_r) + 8'h01)
    else $error("abandoned frame not counted");
  a_abandon_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (!is_excess && !wr_abandon)
      |=> $stable(abandoned_frame_count_r))
    else $error("abandoned counter moved without cause");
  a_abandon_load: assert property (@(posedge clk) disable iff (!rst_n)
    wr_abandon |=> abandoned_frame_count_r == $past(pio_wdata[7:0]))
    else $error("abandoned counter load lost");

  a_late_give_up: assert property (@(posedge clk) disable iff (!rst_n)
    s_late_hit |=> give_up_late && !give_up_excess)
    else $error("late collision not flagged");
  a_excess_give_up: assert property (@(posedge clk) disable iff (!rst_n)
    s_excess_hit |=> give_up_excess && !give_up_late)
    else $error("excess collision not flagged");
  a_quiet_give_up: assert property (@(posedge clk) disable iff (!rst_n)
    !attempt_collided |=> !give_up_late && !give_up_excess)
    else $error("give up without collision");
  a_late_count: assert property (@(posedge clk) disable iff (!rst_n)
    (is_late && !wr_late)
      |=> late_hit_frame_count_r == $past(late_hit_frame_count_r) + 8'h01)
    else $error("late collision not counted");
  a_late_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (!is_late && !wr_late)
      |=> $stable(late_hit_frame_count_r))
    else $error("late counter moved without cause");
  a_late_load: assert property (@(posedge clk) disable iff (!rst_n)
    wr_late |=> late_hit_frame_count_r == $past(pio_wdata[7:0]))
    else $error("late counter load lost");

  a_seed_load: assert property (@(posedge clk) disable iff (!rst_n)
    wr_seed |=> backoff_seed_r == $past(pio_wdata[9:0]))
    else $error("seed not loaded");
  a_seed_moves: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_seed |=> backoff_seed_r != $past(backoff_seed_r))
    else $error("seed not updated");
  a_seed_read: assert property (@(posedge clk) disable iff (!rst_n)
    (pio_rd && pio_addr == TMCS_ADDR_SEED)
      |=> pio_rdata == {22'h000000, $past(backoff_seed_r)})
    else $error("seed view wrong");
  a_state_read: assert property (@(posedge clk) disable iff (!rst_n)
    (pio_rd && pio_addr == TMCS_ADDR_STATE)
      |=> pio_rdata == {24'h000000, $past(encap_fsm), $past(line_manager_fsm)})
    else $error("state view wrong");
endmodule

// ### tmcs_mac_model.sv
`timescale 1ns/10ps
module tmcs_mac_model (
  // clock
  input wire logic clk,
  // events toward the stats block
  output logic deferring,
  output logic attempt_collided,
  output logic attempt_done_ok,
  output logic [7:0] bytes_sent,
  output logic [7:0] attempt_num,
  output logic [3:0] line_manager_fsm,
  output logic [3:0] encap_fsm
);
  initial
  begin
    deferring = 1'b0;
    attempt_collided = 1'b0;
    attempt_done_ok = 1'b0;
    bytes_sent = 8'h00;
    attempt_num = 8'h00;
    line_manager_fsm = 4'h6;
    encap_fsm = 4'h9;
  end
  // qualifiers are inverted outside the pulse so stale values are never trusted
  task automatic send(input logic c, input logic k, input logic [7:0] n, input logic [7:0] b);
    @(negedge clk);
    attempt_collided = c;
    attempt_done_ok = k;
    attempt_num = n;
    bytes_sent = b;
    @(negedge clk);
    attempt_collided = 1'b0;
    attempt_done_ok = 1'b0;
    attempt_num = ~n;
    bytes_sent = ~b;
  endtask
  task automatic defer(input int n);
    @(negedge clk);
    deferring = 1'b1;
    repeat (n) @(negedge clk);
    deferring = 1'b0;
  endtask
endmodule

// ### tmcs_tb.sv
`timescale 1ns/10ps
module tb;
  import tmcs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [27:0] pio_addr = 28'h0000000;
  logic pio_wr = 1'b0;
  logic pio_rd = 1'b0;
  logic [31:0] pio_wdata = 32'h00000000;
  logic [31:0] pio_rdata;
  logic [7:0] max_tries = TMCS_MAX_TRIES_RST;
  logic [7:0] min_send_length = TMCS_MIN_SEND_RST;
  logic deferring, attempt_collided, attempt_done_ok;
  logic [7:0] bytes_sent, attempt_num;
  logic [3:0] line_manager_fsm, encap_fsm;
  logic give_up_late, give_up_excess;
  logic [9:0] backoff_rand;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  localparam logic [27:0] CNT [5] = '{TMCS_ADDR_DEFER, TMCS_ADDR_COLL, TMCS_ADDR_SECOND,
    TMCS_ADDR_ABANDON, TMCS_ADDR_LATE};
  always #4 clk = ~clk;
  tmcs_mac_model mac (.clk(clk), .deferring(deferring), .attempt_collided(attempt_collided),
    .attempt_done_ok(attempt_done_ok), .bytes_sent(bytes_sent), .attempt_num(attempt_num),
    .line_manager_fsm(line_manager_fsm), .encap_fsm(encap_fsm));
  tmcs_stats dut (.clk(clk), .rst_n(rst_n), .pio_addr(pio_addr), .pio_wr(pio_wr),
    .pio_rd(pio_rd), .pio_wdata(pio_wdata), .pio_rdata(pio_rdata), .max_tries(max_tries),
    .min_send_length(min_send_length), .deferring(deferring),
    .attempt_collided(attempt_collided), .attempt_done_ok(attempt_done_ok),
    .bytes_sent(bytes_sent), .attempt_num(attempt_num), .line_manager_fsm(line_manager_fsm),
    .encap_fsm(encap_fsm), .give_up_late(give_up_late), .give_up_excess(give_up_excess),
    .backoff_rand(backoff_rand));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("Error %s: expected %h, seen %h", w, e, s);
    end
  endtask
  task automatic wr(input logic [27:0] a, input logic [31:0] d);
    @(negedge clk);
    pio_addr = a;
    pio_wdata = d;
    pio_wr = 1'b1;
    @(negedge clk);
    pio_wr = 1'b0;
    pio_wdata = ~d;
  endtask
  task automatic rd(input logic [27:0] a, input logic [31:0] e, input string w);
    @(negedge clk);
    pio_addr = a;
    pio_rd = 1'b1;
    @(negedge clk);
    pio_rd = 1'b0;
    chk(w, pio_rdata, e);
  endtask
  // a pulse, then both give-up flags in the following cycle
  task automatic ev(input logic [7:0] n, input logic [7:0] b, input logic l, input logic x);
    mac.send(1'b1, 1'b0, n, b);
    chk("give_up_late", give_up_late, l);
    chk("give_up_excess", give_up_excess, x);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    for (int i = 0; i < 5; i++)
      rd(CNT[i], 0, "reset value");
    rd(TMCS_ADDR_STATE, 32'h00000096, "state view");
    wr(TMCS_ADDR_STATE, 32'h0000005A);
    rd(TMCS_ADDR_STATE, 32'h00000096, "state read-only");
    rd(28'h8C06258, 0, "unmapped");
    $display("reset test done");
  endtask
  task automatic t_load;
    for (int i = 0; i < 5; i++)
    begin
      wr(CNT[i], 32'hFFFFA5C3);
      rd(CNT[i], (i < 3) ? 32'h0000A5C3 : 32'h000000C3, "load");
      wr(CNT[i], 0);
    end
    $display("load test done");
  endtask
  task automatic t_events;
    ev(8'h01, 8'h10, 1'b0, 1'b0);
    mac.send(1'b0, 1'b1, 8'h02, 8'h00);
    mac.send(1'b0, 1'b1, 8'h01, 8'h00);
    ev(8'h02, 8'h40, 1'b1, 1'b0);
    ev(8'h10, 8'h3F, 1'b0, 1'b1);
    ev(8'h10, 8'h40, 1'b1, 1'b0);
    rd(TMCS_ADDR_COLL, 4, "collisions");
    rd(TMCS_ADDR_SECOND, 1, "second try");
    rd(TMCS_ADDR_ABANDON, 1, "abandoned");
    rd(TMCS_ADDR_LATE, 2, "late");
    $display("event test done");
  endtask
  task automatic t_wrap;
    wr(TMCS_ADDR_LATE, 32'h000000FF);
    ev(8'h01, 8'h80, 1'b1, 1'b0);
    rd(TMCS_ADDR_LATE, 0, "late wrap");
    fork
      wr(TMCS_ADDR_COLL, 32'h00001234);
      mac.send(1'b1, 1'b0, 8'h01, 8'h00);
    join
    rd(TMCS_ADDR_COLL, 32'h00001234, "write wins");
    $display("wrap test done");
  endtask
  // narrower limits than the reset values, so both settings really steer the decisions
  task automatic t_limits;
    @(negedge clk);
    max_tries = 8'h03;
    min_send_length = 8'h20;
    ev(8'h02, 8'h1F, 1'b0, 1'b0);
    ev(8'h03, 8'h1F, 1'b0, 1'b1);
    ev(8'h03, 8'h20, 1'b1, 1'b0);
    @(negedge clk);
    max_tries = TMCS_MAX_TRIES_RST;
    min_send_length = TMCS_MIN_SEND_RST;
    rd(TMCS_ADDR_COLL, 32'h00001237, "collisions after limit");
    rd(TMCS_ADDR_ABANDON, 2, "abandoned after limit");
    rd(TMCS_ADDR_LATE, 1, "late after limit");
    $display("limit test done");
  endtask
  task automatic t_defer;
    wr(TMCS_ADDR_DEFER, 32'h0000FFFF);
    mac.defer(2 * TMCS_DEFER_DIV);
    rd(TMCS_ADDR_DEFER, 1, "defer ticks");
    repeat (2 * TMCS_DEFER_DIV) @(negedge clk);
    rd(TMCS_ADDR_DEFER, 1, "defer idle");
    $display("defer test done");
  endtask
  task automatic t_seed;
    // station address low bits keep stations apart
    wr(TMCS_ADDR_SEED, 32'h000002B5);
    chk("seed load", backoff_rand, 10'h2B5);
    @(negedge clk);
    chk("seed moves", backoff_rand !== 10'h2B5, 1);
    // all ones must not freeze the generator
    wr(TMCS_ADDR_SEED, 32'h000003FF);
    chk("seed all ones", backoff_rand, 10'h3FF);
    @(negedge clk);
    chk("seed leaves all ones", backoff_rand !== 10'h3FF, 1);
    $display("seed test done");
  endtask
  task automatic conclude;
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // a hang is cut short well past the expected 1150 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      conclude();
    end
  end
  initial
  begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_load();
    t_events();
    t_wrap();
    t_limits();
    t_defer();
    t_seed();
    conclude();
  end
endmodule
